// file: shared/intprio_pkg.sv
package intprio_pkg;
   localparam int NUM_MASKABLE = 15;
   localparam int IDX_W = 4;
   localparam int SRC_W = 5;
   // APB map
   localparam logic [7:0] ADDR_CC_MASK = 8'h00;
   localparam logic [7:0] ADDR_OPTION = 8'h04;
   localparam logic [7:0] ADDR_PROMOTED = 8'h08;
   localparam logic [7:0] ADDR_EXT_FLAG = 8'h0C;
   localparam logic [7:0] ADDR_PENDING = 8'h10;
   // Field positions
   localparam int CC_X_POS = 6;
   localparam int CC_I_POS = 4;
   localparam int OPT_EDGE_POS = 5;
   localparam int EXT_FLAG_POS = 0;
   localparam int PEND_NMI_POS = 15;
   localparam int PEND_ILL_POS = 16;
   localparam int PEND_TRAP_POS = 17;
   // Promotion codes
   localparam logic [4:0] PSEL_FIRST = 5'h06;
   localparam logic [4:0] PSEL_LAST = 5'h14;
   localparam logic [4:0] PSEL_RESET = 5'h06;
   localparam logic EDGE_RESET = 1'b0;
   // Edge select window, bus-clock cycles
   localparam logic [6:0] EDGE_WIN_CYC = 7'h40;
   // Vectors; maskable index i sits at base minus step times i
   localparam logic [15:0] VEC_MASK_BASE = 16'hFFF2;
   localparam logic [15:0] VEC_STEP = 16'h0002;
   localparam logic [15:0] VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
   localparam logic [15:0] VEC_WDOG = 16'hFFFA;
   localparam logic [15:0] VEC_ILLEGAL = 16'hFFF8;
   localparam logic [15:0] VEC_TRAP = 16'hFFF6;
   localparam logic [15:0] VEC_NMI_PIN = 16'hFFF4;
   // Source codes reported on the source output
   localparam logic [4:0] SRC_NONE = 5'h1F;
   localparam logic [4:0] SRC_RESET = 5'h10;
   localparam logic [4:0] SRC_CLKMON = 5'h11;
   localparam logic [4:0] SRC_WDOG = 5'h12;
   localparam logic [4:0] SRC_NMI_PIN = 5'h13;
   localparam logic [4:0] SRC_ILLEGAL = 5'h14;
   localparam logic [4:0] SRC_TRAP = 5'h15;
   typedef enum logic [1:0] {ST_IDLE, ST_STACK, ST_RESET} svc_state_t;
endpackage : intprio_pkg

// file: design/maskable_picker.sv
`timescale 1ns/1ps
`default_nettype none
module maskable_picker
   import intprio_pkg::*;
(
   // Requests, already gated by local enables
   input wire logic [NUM_MASKABLE-1:0] req_i,
   // Promotion code
   input wire logic [4:0] psel_i,
   // Result
   output logic any_o,
   output logic [IDX_W-1:0] idx_o
);
   logic [NUM_MASKABLE:0] none_below;
   logic [NUM_MASKABLE-1:0] first;
   logic psel_ok;
   logic [4:0] psel_off;
   logic [IDX_W-1:0] promoted;
   logic [IDX_W-1:0] lowest;
   logic [IDX_W-1:0] acc;

   assign psel_ok = (psel_i >= PSEL_FIRST) && (psel_i <= PSEL_LAST);
   assign psel_off = psel_i - PSEL_FIRST;
   assign promoted = psel_ok ? psel_off[IDX_W-1:0] : '0;
   assign none_below[0] = 1'b1;

   genvar g;
   generate
      for (g = 0; g < NUM_MASKABLE; g++) begin : g_chain
         assign none_below[g+1] = none_below[g] & ~req_i[g];
         assign first[g] = req_i[g] & none_below[g];
      end
   endgenerate

   always_comb begin
      acc = '0;
      for (int k = 0; k < NUM_MASKABLE; k++) begin
         if (first[k]) begin
            acc = acc | IDX_W'(k);
         end
      end
      lowest = acc;
   end

   assign any_o = |req_i;
   // Promoted wins only if requesting itself; masks were applied upstream
   assign idx_o = req_i[promoted] ? promoted : lowest;
endmodule : maskable_picker
`default_nettype wire

// file: design/interrupt_priority_logic.sv
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_logic
   import intprio_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_B_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Reset sources
   input wire logic POR_I,
   input wire logic CLKMON_FAIL_I,
   input wire logic WATCHDOG_TIMER_I,
   // Pins
   input wire logic NONMASKABLE_INT_PIN_B_I,
   input wire logic EXT_INT_PIN_B_I,
   input wire logic SPECIAL_MODE_I,
   // Peripheral requests, locally enabled, default order after the pin
   input wire logic [NUM_MASKABLE-2:0] PERIPH_REQ_I,
   // CPU core
   input wire logic INSTR_DONE_I,
   input wire logic OPCODE_UNDEF_I,
   input wire logic [15:0] OPCODE_ADDR_I,
   input wire logic SOFTWARE_TRAP_INSTRUCTION_I,
   input wire logic [15:0] NEXT_PC_I,
   input wire logic CC_STACKED_I,
   input wire logic RETURN_FROM_INTERRUPT_I,
   input wire logic RET_X_I,
   input wire logic RET_I_I,
   input wire logic TAP_I,
   input wire logic TAP_X_I,
   input wire logic TAP_I_BIT_I,
   // To CPU core
   output logic SERVICE_O,
   output logic RESET_REQ_O,
   output logic [15:0] VECTOR_O,
   output logic [15:0] STACK_PC_O,
   output logic [4:0] SOURCE_O,
   output logic MASK_X_O,
   output logic MASK_I_O
);
   logic rst_s1;
   logic rst_n;
   svc_state_t state;
   svc_state_t next_state;
   logic x_mask;
   logic i_mask;
   logic edge_select_bit;
   logic edge_written;
   logic [6:0] win_cnt;
   logic [4:0] psel;
   logic ext_flag;
   logic ext_pin_q;
   logic ill_pend;
   logic [15:0] ill_addr;
   logic trap_pend;
   logic taken_nmi;

   // Reset release through two flops
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // APB decode; one wait cycle so read data comes from a flop
   logic acc_phase;
   logic commit;
   logic wr_commit;
   logic hit_cc;
   logic hit_opt;
   logic hit_prom;
   logic hit_flag;
   logic hit_pend;
   logic mapped;
   logic [31:0] rdata;

   assign acc_phase = PSEL_I & PENABLE_I;
   assign commit = acc_phase & PREADY_O;
   assign wr_commit = commit & PWRITE_I & mapped;
   assign hit_cc = (PADDR_I == ADDR_CC_MASK);
   assign hit_opt = (PADDR_I == ADDR_OPTION);
   assign hit_prom = (PADDR_I == ADDR_PROMOTED);
   assign hit_flag = (PADDR_I == ADDR_EXT_FLAG);
   assign hit_pend = (PADDR_I == ADDR_PENDING);
   assign mapped = hit_cc | hit_opt | hit_prom | hit_flag | hit_pend;

   // Maskable request vector: pin first, then peripherals
   logic [NUM_MASKABLE-1:0] mreq;
   logic m_any;
   logic [IDX_W-1:0] m_idx;
   logic nmi_req;

   assign mreq = {PERIPH_REQ_I, ext_flag};
   assign nmi_req = ~NONMASKABLE_INT_PIN_B_I & ~x_mask;

   maskable_picker u_picker (
      .req_i(mreq),
      .psel_i(psel),
      .any_o(m_any),
      .idx_o(m_idx)
   );

   always_comb begin
      rdata = 32'h0000_0000;
      if (hit_cc) begin
         rdata[CC_X_POS] = x_mask;
         rdata[CC_I_POS] = i_mask;
      end else if (hit_opt) begin
         rdata[OPT_EDGE_POS] = edge_select_bit;
      end else if (hit_prom) begin
         rdata[4:0] = psel;
      end else if (hit_flag) begin
         rdata[EXT_FLAG_POS] = ext_flag;
      end else if (hit_pend) begin
         rdata[NUM_MASKABLE-1:0] = mreq;
         rdata[PEND_NMI_POS] = nmi_req;
         rdata[PEND_ILL_POS] = ill_pend;
         rdata[PEND_TRAP_POS] = trap_pend;
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         PREADY_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O <= acc_phase & ~PREADY_O;
         PRDATA_O <= (acc_phase & ~PWRITE_I) ? rdata : 32'h0000_0000;
         PSLVERR_O <= acc_phase & ~PREADY_O & ~mapped;
      end
   end

   // Edge select window and single write; special mode allows any number of writes
   logic win_open;
   logic edge_wr;

   assign win_open = (win_cnt < EDGE_WIN_CYC);
   assign edge_wr = wr_commit & hit_opt & (SPECIAL_MODE_I | (win_open & ~edge_written));

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         win_cnt <= 7'h00;
         edge_written <= 1'b0;
         edge_select_bit <= EDGE_RESET;
      end else begin
         if (win_open) begin
            win_cnt <= win_cnt + 7'h01;
         end
         if (edge_wr) begin
            edge_written <= 1'b1;
            edge_select_bit <= PWDATA_I[OPT_EDGE_POS];
         end
      end
   end

   // Promotion field, guarded by the global mask to avoid races
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         psel <= PSEL_RESET;
      end else if (wr_commit & hit_prom & i_mask) begin
         psel <= PWDATA_I[4:0];
      end
   end

   // External pin flag; a new event beats a clear in the same cycle
   logic ext_set;
   logic ext_clr;

   assign ext_set = edge_select_bit ? (ext_pin_q & ~EXT_INT_PIN_B_I) : ~EXT_INT_PIN_B_I;
   assign ext_clr = wr_commit & hit_flag & PWDATA_I[EXT_FLAG_POS];

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ext_pin_q <= 1'b1;
         ext_flag <= 1'b0;
      end else begin
         ext_pin_q <= EXT_INT_PIN_B_I;
         ext_flag <= (ext_flag & ~ext_clr) | ext_set;
      end
   end

   // Nonmaskable selection at instruction boundary
   logic any_reset;
   logic take;
   logic [15:0] sel_vec;
   logic [4:0] sel_src;
   logic sel_nmi;
   logic sel_ill;
   logic sel_trap;
   logic [15:0] m_vec;
   logic [15:0] sel_pc;

   assign any_reset = POR_I | CLKMON_FAIL_I | WATCHDOG_TIMER_I;
   assign m_vec = VEC_MASK_BASE - (VEC_STEP * 16'(m_idx));
   assign sel_nmi = nmi_req;
   assign sel_ill = ~sel_nmi & ill_pend;
   assign sel_trap = ~sel_nmi & ~ill_pend & trap_pend;
   assign take = (state == ST_IDLE) & INSTR_DONE_I
               & (sel_nmi | ill_pend | trap_pend | (m_any & ~i_mask));
   assign sel_pc = sel_ill ? ill_addr : NEXT_PC_I;

   always_comb begin
      sel_vec = m_vec;
      sel_src = {1'b0, m_idx};
      if (POR_I) begin
         sel_vec = VEC_RESET;
         sel_src = SRC_RESET;
      end else if (CLKMON_FAIL_I) begin
         sel_vec = VEC_CLKMON;
         sel_src = SRC_CLKMON;
      end else if (WATCHDOG_TIMER_I) begin
         sel_vec = VEC_WDOG;
         sel_src = SRC_WDOG;
      end else if (sel_nmi) begin
         sel_vec = VEC_NMI_PIN;
         sel_src = SRC_NMI_PIN;
      end else if (sel_ill) begin
         sel_vec = VEC_ILLEGAL;
         sel_src = SRC_ILLEGAL;
      end else if (sel_trap) begin
         sel_vec = VEC_TRAP;
         sel_src = SRC_TRAP;
      end
   end

   // Trap requests held until their service begins; set wins
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ill_pend <= 1'b0;
         ill_addr <= 16'h0000;
         trap_pend <= 1'b0;
      end else begin
         ill_pend <= (ill_pend & ~(take & sel_ill)) | OPCODE_UNDEF_I;
         trap_pend <= (trap_pend & ~(take & sel_trap)) | SOFTWARE_TRAP_INSTRUCTION_I;
         if (OPCODE_UNDEF_I) begin
            ill_addr <= OPCODE_ADDR_I;
         end
      end
   end

   // Service sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = ST_STACK;
            end
         end
         ST_STACK: begin
            if (CC_STACKED_I) begin
               next_state = ST_IDLE;
            end
         end
         ST_RESET: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (any_reset) begin
         next_state = ST_RESET;
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_RESET;
         taken_nmi <= 1'b0;
      end else begin
         state <= next_state;
         if (take) begin
            taken_nmi <= sel_nmi;
         end
      end
   end

   // Mask flags of the condition code register
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         x_mask <= 1'b1;
         i_mask <= 1'b1;
      end else if (any_reset) begin
         x_mask <= 1'b1;
         i_mask <= 1'b1;
      end else if (state == ST_STACK && CC_STACKED_I) begin
         i_mask <= 1'b1;
         if (taken_nmi) begin
            x_mask <= 1'b1;
         end
      end else if (RETURN_FROM_INTERRUPT_I) begin
         x_mask <= RET_X_I;
         i_mask <= RET_I_I;
      end else if (TAP_I) begin
         // Software may only clear the pin mask, never set it
         x_mask <= x_mask & TAP_X_I;
         i_mask <= TAP_I_BIT_I;
      end
   end

   // Outputs to the core
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         SERVICE_O <= 1'b0;
         RESET_REQ_O <= 1'b1;
         VECTOR_O <= VEC_RESET;
         STACK_PC_O <= 16'h0000;
         SOURCE_O <= SRC_RESET;
         MASK_X_O <= 1'b1;
         MASK_I_O <= 1'b1;
      end else begin
         SERVICE_O <= take & ~any_reset;
         RESET_REQ_O <= any_reset;
         MASK_X_O <= x_mask;
         MASK_I_O <= i_mask;
         if (any_reset | take) begin
            VECTOR_O <= sel_vec;
            SOURCE_O <= sel_src;
            STACK_PC_O <= sel_pc;
         end else if (state == ST_IDLE) begin
            SOURCE_O <= SRC_NONE;
         end
      end
   end
endmodule : interrupt_priority_logic
`default_nettype wire

// file: dv/intprio_properties.sv
`timescale 1ns/1ps
`default_nettype none
module intprio_checker
   import intprio_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_B_I,
   // APB
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // Core and reset sources
   input wire logic POR_I,
   input wire logic CLKMON_FAIL_I,
   input wire logic WATCHDOG_TIMER_I,
   input wire logic INSTR_DONE_I,
   input wire logic CC_STACKED_I,
   input wire logic RETURN_FROM_INTERRUPT_I,
   input wire logic TAP_I,
   // Results
   input wire logic SERVICE_O,
   input wire logic RESET_REQ_O,
   input wire logic [15:0] VECTOR_O,
   input wire logic [4:0] SOURCE_O,
   input wire logic MASK_X_O,
   input wire logic MASK_I_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   wire rst_any = POR_I | CLKMON_FAIL_I | WATCHDOG_TIMER_I;
   reset_req_a: assert property (rst_any |=> RESET_REQ_O)
      else $error("reset request missing");
   reset_vec_a: assert property (POR_I |=> VECTOR_O == VEC_RESET)
      else $error("reset vector wrong");
   svc_pulse_a: assert property (SERVICE_O |=> !SERVICE_O)
      else $error("service longer than one cycle");
   svc_done_a: assert property (SERVICE_O |-> $past(INSTR_DONE_I))
      else $error("service outside instruction end");
   mask_vec_a: assert property (SERVICE_O && SOURCE_O < 5'h0F |->
      VECTOR_O == VEC_MASK_BASE - VEC_STEP * 16'(SOURCE_O))
      else $error("maskable vector wrong");
   pin_vec_a: assert property (SERVICE_O && SOURCE_O == SRC_NMI_PIN |->
      VECTOR_O == VEC_NMI_PIN)
      else $error("pin vector wrong");
   stack_i_a: assert property (CC_STACKED_I |-> ##2 MASK_I_O)
      else $error("global mask not set after stacking");
   x_rise_a: assert property ($rose(MASK_X_O) |-> $past(RETURN_FROM_INTERRUPT_I, 2)
      || $past(CC_STACKED_I, 2) || $past(RESET_REQ_O))
      else $error("pin mask set without cause");
   i_fall_a: assert property ($fell(MASK_I_O) |->
      $past(TAP_I, 2) || $past(RETURN_FROM_INTERRUPT_I, 2))
      else $error("global mask cleared without cause");
   apb_wait_a: assert property (PSEL_I && !PENABLE_I |=> !PREADY_O ##1 PREADY_O)
      else $error("ready timing wrong");
   apb_err_a: assert property (PREADY_O |->
      PSLVERR_O == (PADDR_I > 8'h10 || PADDR_I[1:0] != 2'h0))
      else $error("slave error wrong");
endmodule : intprio_checker
`default_nettype wire

// file: dv/core_stack_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_stack_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Service handshake
   input wire logic service_i,
   input wire logic [3:0] delay_i,
   output logic stacked_o
);
   logic [4:0] cnt;
   // Stacking length varies, so flag updates must wait for it
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt <= 5'h00;
         stacked_o <= 1'b0;
      end else begin
         stacked_o <= (cnt == 5'h01);
         if (service_i)
            cnt <= {1'b0, delay_i} + 5'h01;
         else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
      end
   end
endmodule : core_stack_model
`default_nettype wire

// file: dv/test_interrupt_priority_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_priority_logic
   import intprio_pkg::*;
;
   logic CLK_I = 1'b0, RST_B_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
   logic POR_I = 1'b0, CLKMON_FAIL_I = 1'b0, WATCHDOG_TIMER_I = 1'b0, SPECIAL_MODE_I = 1'b0;
   logic NONMASKABLE_INT_PIN_B_I = 1'b1, EXT_INT_PIN_B_I = 1'b1, INSTR_DONE_I = 1'b0;
   logic OPCODE_UNDEF_I = 1'b0, SOFTWARE_TRAP_INSTRUCTION_I = 1'b0;
   logic RETURN_FROM_INTERRUPT_I = 1'b0, RET_X_I = 1'b0, RET_I_I = 1'b0;
   logic TAP_I = 1'b0, TAP_X_I = 1'b0, TAP_I_BIT_I = 1'b0, er;
   logic CC_STACKED_I, PREADY_O, PSLVERR_O, SERVICE_O, RESET_REQ_O, MASK_X_O, MASK_I_O;
   logic [7:0] PADDR_I = 8'h00;
   logic [31:0] PWDATA_I = 32'h0000_0000, PRDATA_O, rd;
   logic [13:0] PERIPH_REQ_I = 14'h0000;
   logic [15:0] OPCODE_ADDR_I = 16'h1234, NEXT_PC_I = 16'h5678, VECTOR_O, STACK_PC_O;
   logic [4:0] SOURCE_O;
   logic [3:0] dly = 4'h0;
   localparam logic [31:0] zero = 32'h0000_0000;
   int fails = 0, checked = 0;
   typedef struct packed {
      logic [4:0] psel;
      logic [13:0] req;
      logic [4:0] src;
      logic [15:0] vec;
   } row_t;
   row_t rows [6] = '{'{5'h06, 14'h0011, 5'h01, 16'hFFF0}, '{5'h0B, 14'h0011, 5'h05, 16'hFFE8},
      '{5'h14, 14'h2001, 5'h0E, 16'hFFD6}, '{5'h15, 14'h2001, 5'h01, 16'hFFF0},
      '{5'h05, 14'h2004, 5'h03, 16'hFFEC}, '{5'h10, 14'h0208, 5'h0A, 16'hFFDE}};
   interrupt_priority_logic i_dut (.*);
   core_stack_model i_core (.clk_i(CLK_I), .rst_b_i(RST_B_I), .service_i(SERVICE_O),
      .delay_i(dly), .stacked_o(CC_STACKED_I));
   initial forever #2.5 CLK_I = ~CLK_I;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         fails++;
      end
   endtask : chk
   task automatic give_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic hold(ref logic s, input string what);
      int n = 0;
      do begin
         @(posedge CLK_I);
         n++;
      end while (s !== 1'b1 && n < 40);
      if (s !== 1'b1) begin
         chk(what, zero, 32'h0000_0001);
         give_verdict();
      end
   endtask : hold
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL_I <= 1'b1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge CLK_I);
      PENABLE_I <= 1'b1;
      hold(PREADY_O, "ready");
      rd = PRDATA_O;
      er = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
      @(posedge CLK_I);
   endtask : apb
   task automatic tap(input logic x, input logic i);
      TAP_I <= 1'b1;
      TAP_X_I <= x;
      TAP_I_BIT_I <= i;
      @(posedge CLK_I);
      TAP_I <= 1'b0;
      repeat (2) @(posedge CLK_I);
   endtask : tap
   task automatic take(input logic [4:0] src, input logic [15:0] vec);
      INSTR_DONE_I <= 1'b1;
      @(posedge CLK_I);
      INSTR_DONE_I <= 1'b0;
      hold(SERVICE_O, "service");
      chk("source", SOURCE_O, src);
      chk("vector", VECTOR_O, vec);
      hold(CC_STACKED_I, "stacking");
      repeat (2) @(posedge CLK_I);
   endtask : take
   initial begin
      repeat (12) @(posedge CLK_I);
      chk("vector", VECTOR_O, VEC_RESET);
      chk("masks", {MASK_X_O, MASK_I_O}, 2'h3);
      RST_B_I <= 1'b1;
      repeat (3) @(posedge CLK_I);
      apb(1'b0, ADDR_OPTION, zero);
      chk("edge select", rd, zero);
      apb(1'b1, ADDR_OPTION, 32'h0000_0020);
      apb(1'b1, ADDR_OPTION, zero);
      apb(1'b0, ADDR_OPTION, zero);
      chk("edge select", rd, 32'h0000_0020);
      apb(1'b0, ADDR_CC_MASK, zero);
      chk("cc", rd, 32'h0000_0050);
      apb(1'b0, ADDR_PROMOTED, zero);
      chk("promotion", rd, 32'h0000_0006);
      $display("reset test done");
      EXT_INT_PIN_B_I <= 1'b0;
      apb(1'b0, ADDR_EXT_FLAG, zero);
      chk("pin flag", rd, 32'h0000_0001);
      apb(1'b0, ADDR_PENDING, zero);
      chk("pending", rd, 32'h0000_0001);
      tap(1'b1, 1'b0);
      take(5'h00, 16'hFFF2);
      apb(1'b1, ADDR_EXT_FLAG, 32'h0000_0001);
      apb(1'b0, ADDR_EXT_FLAG, zero);
      chk("pin flag", rd, zero);
      EXT_INT_PIN_B_I <= 1'b1;
      $display("pin test done");
      foreach (rows[k]) begin
         dly <= 4'(k * 3);
         apb(1'b1, ADDR_PROMOTED, 32'(rows[k].psel));
         apb(1'b0, ADDR_PROMOTED, zero);
         chk("promotion", rd, 32'(rows[k].psel));
         PERIPH_REQ_I <= rows[k].req;
         tap(1'b1, 1'b0);
         take(rows[k].src, rows[k].vec);
         PERIPH_REQ_I <= 14'h0000;
      end
      $display("priority rows done");
      tap(1'b1, 1'b0);
      apb(1'b1, ADDR_PROMOTED, 32'h0000_000B);
      apb(1'b0, ADDR_PROMOTED, zero);
      chk("promotion", rd, 32'h0000_0010);
      OPCODE_UNDEF_I <= 1'b1;
      SOFTWARE_TRAP_INSTRUCTION_I <= 1'b1;
      @(posedge CLK_I);
      OPCODE_UNDEF_I <= 1'b0;
      SOFTWARE_TRAP_INSTRUCTION_I <= 1'b0;
      apb(1'b0, ADDR_PENDING, zero);
      chk("pending", rd, 32'h0003_0000);
      take(SRC_ILLEGAL, VEC_ILLEGAL);
      chk("stacked pc", STACK_PC_O, 16'h1234);
      take(SRC_TRAP, VEC_TRAP);
      chk("stacked pc", STACK_PC_O, 16'h5678);
      tap(1'b0, 1'b1);
      NONMASKABLE_INT_PIN_B_I <= 1'b0;
      PERIPH_REQ_I <= 14'h0001;
      take(SRC_NMI_PIN, VEC_NMI_PIN);
      chk("masks", {MASK_X_O, MASK_I_O}, 2'h3);
      NONMASKABLE_INT_PIN_B_I <= 1'b1;
      RETURN_FROM_INTERRUPT_I <= 1'b1;
      @(posedge CLK_I);
      RETURN_FROM_INTERRUPT_I <= 1'b0;
      repeat (2) @(posedge CLK_I);
      chk("masks", {MASK_X_O, MASK_I_O}, 2'h0);
      tap(1'b1, 1'b1);
      chk("pin mask", MASK_X_O, 1'b0);
      tap(1'b0, 1'b0);
      take(5'h01, 16'hFFF0);
      chk("masks", {MASK_X_O, MASK_I_O}, 2'h1);
      PERIPH_REQ_I <= 14'h0000;
      $display("nonmaskable test done");
      for (int k = 0; k < 3; k++) begin
         {POR_I, CLKMON_FAIL_I, WATCHDOG_TIMER_I} <= 3'h7 >> k;
         repeat (3) @(posedge CLK_I);
         chk("reset vector", VECTOR_O, 16'hFFFE - 16'(2 * k));
      end
      {POR_I, CLKMON_FAIL_I, WATCHDOG_TIMER_I} <= 3'h0;
      repeat (3) @(posedge CLK_I);
      chk("reset request", RESET_REQ_O, 1'b0);
      apb(1'b0, 8'h20, zero);
      chk("slave error", er, 1'b1);
      RST_B_I <= 1'b0;
      repeat (2) @(posedge CLK_I);
      RST_B_I <= 1'b1;
      repeat (70) @(posedge CLK_I);
      apb(1'b1, ADDR_OPTION, 32'h0000_0020);
      apb(1'b0, ADDR_OPTION, zero);
      chk("edge select", rd, zero);
      EXT_INT_PIN_B_I <= 1'b0;
      apb(1'b1, ADDR_EXT_FLAG, 32'h0000_0001);
      apb(1'b0, ADDR_EXT_FLAG, zero);
      chk("pin flag", rd, 32'h0000_0001);
      EXT_INT_PIN_B_I <= 1'b1;
      apb(1'b1, ADDR_EXT_FLAG, 32'h0000_0001);
      apb(1'b0, ADDR_EXT_FLAG, zero);
      chk("pin flag", rd, zero);
      SPECIAL_MODE_I <= 1'b1;
      apb(1'b1, ADDR_OPTION, 32'h0000_0020);
      apb(1'b0, ADDR_OPTION, zero);
      chk("edge select", rd, 32'h0000_0020);
      $display("window test done");
      give_verdict();
   end
endmodule : test_interrupt_priority_logic
bind interrupt_priority_logic intprio_checker i_chk (.*);
`default_nettype wire
